// file: verilog/baud_pkg.sv
// Constants and types shared by the bit-rate clock generator.
package baud_pkg;
  typedef enum logic [1:0] {
    MODE_ASYNC = 2'h0,
    MODE_SYNC_MASTER = 2'h1,
    MODE_SYNC_SLAVE = 2'h2,
    MODE_SPI_MASTER = 2'h3
  } clk_mode_t;
  localparam int unsigned PERIOD_W = 12;
  localparam logic [11:0] PERIOD_MAX = 12'hfff;
  localparam logic [3:0] SCALE_MAX = 4'h7;
  localparam logic [3:0] SCALE_MIN = 4'h9;
  localparam logic [4:0] OS_NORMAL = 5'h10;
  localparam logic [4:0] OS_DOUBLE = 5'h08;
  localparam logic RST_XCK = 1'b0;
  localparam logic [11:0] RST_PERIOD = 12'h000;
endpackage

// file: verilog/xfer_clk_sync.sv
// Two-stage synchroniser and edge detector for the transfer clock pin.
`timescale 1ns/1ps
module xfer_clk_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Pin from the far party
  input wire logic pin,
  // Synchronised edges, one cycle each
  output logic rise,
  output logic fall
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // Only the second stage reads the first, so metastability cannot spread.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign rise = s2_q & ~s3_q;
  assign fall = ~s2_q & s3_q;
endmodule

// file: verilog/baud_clock_gen.sv
// Fractional bit-rate clock generator for the serial transceiver.
//
// Contract
// - Four clocking modes; bit clock internal or from the transfer clock pin.
// - Internal generator serves async, synchronous master and SPI master.
// - Synchronous slave takes its bit clock from the transfer clock pin.
// - Period setting is 12 bits, any value 0 to 4095.
// - Scale exponent is signed -7 to +7 for fractional division.
// - Normal async rate uses factor 16, with 2^scale or fractional period.
// - Double speed uses factor 8 instead of 16.
// - Synchronous and SPI master rate is clock over 2*(period+1).
// - Pin clock is sampled, must run below a quarter of clk.
// - Double speed receiver uses 8 samples per bit, else 16.
`timescale 1ns/1ps
module baud_clock_gen (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Configuration
  input wire logic enable,
  input wire logic [1:0] clock_mode,
  input wire logic double_speed_select,
  input wire logic [11:0] rate_period_setting,
  input wire logic [3:0] rate_scale_exponent,
  // Transfer clock pin
  input wire logic transfer_clock_pin_in,
  output logic transfer_clock_pin_out,
  output logic transfer_clock_pin_oe,
  // Ticks and samples per bit to the shift logic
  output logic sample_tick,
  output logic bit_tick,
  output logic setup_tick,
  output logic [4:0] samples_per_bit
);
  // Values of -8 are clamped to -7, the last legal magnitude.
  function automatic logic [2:0] scale_mag(input logic [3:0] s);
    if (s == 4'h8) begin
      return 3'h7;
    end else if (s[3]) begin
      return 3'(4'(~s + 4'h1));
    end else begin
      return s[2:0];
    end
  endfunction

  function automatic logic [7:0] pow2(input logic [2:0] m);
    return 8'(8'h01 << m);
  endfunction

  baud_pkg::clk_mode_t mode;
  logic is_async;
  logic is_master;
  logic neg;
  logic [2:0] mag;
  logic [6:0] mask;
  logic [11:0] shr;
  logic [7:0] frac_sum;
  logic carry;
  logic [6:0] frac_d;
  logic [11:0] reload_d;
  logic [11:0] first_reload;
  logic [6:0] sc_last;
  logic [4:0] spb;
  logic [18:0] cfg;
  logic [18:0] cfg_q;
  logic restart;
  logic pre_tick;
  logic itick;
  logic [11:0] cnt_q;
  logic [6:0] frac_q;
  logic [6:0] sc_q;
  logic [4:0] os_q;
  logic xck_q;
  logic pin_rise;
  logic pin_fall;

  assign mode = baud_pkg::clk_mode_t'(clock_mode);
  assign is_async = mode == baud_pkg::MODE_ASYNC;
  assign is_master = mode == baud_pkg::MODE_SYNC_MASTER ||
                     mode == baud_pkg::MODE_SPI_MASTER;
  assign mag = is_async ? scale_mag(rate_scale_exponent) : 3'h0;
  assign neg = is_async & rate_scale_exponent[3] & (mag != 3'h0);
  assign mask = 7'(pow2(mag) - 8'h01);
  assign shr = 12'(rate_period_setting >> mag);
  // The low bits dropped by the shift build up here and add one cycle
  // whenever they overflow, which gives the fractional period on average.
  assign frac_sum = {1'b0, frac_q} + {1'b0, rate_period_setting[6:0] & mask};
  assign carry = neg && (frac_sum >= pow2(mag));
  assign frac_d = 7'(frac_sum - (carry ? pow2(mag) : 8'h00));
  assign first_reload = neg ? shr : rate_period_setting;
  assign reload_d = neg ? 12'(shr + {11'h000, carry}) : rate_period_setting;
  assign sc_last = (is_async && !neg) ? 7'(pow2(mag) - 8'h01) : 7'h00;
  assign spb = double_speed_select ? baud_pkg::OS_DOUBLE
                                   : baud_pkg::OS_NORMAL;

  assign cfg = {clock_mode, double_speed_select, rate_period_setting,
                rate_scale_exponent};
  assign restart = (cfg != cfg_q) || !enable;
  assign pre_tick = !restart && (is_async || is_master) &&
                    (cnt_q == 12'h000);
  assign itick = pre_tick && (sc_q == sc_last);

  xfer_clk_sync u_sync (
    .clk(clk),
    .resetn(resetn),
    .pin(transfer_clock_pin_in),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg_q <= 19'h00000;
    end else begin
      cfg_q <= cfg;
    end
  end

  // Rate divider: one pre-tick per expiry of the down-counter.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= baud_pkg::RST_PERIOD;
      frac_q <= 7'h00;
      sc_q <= 7'h00;
    end else if (restart) begin
      cnt_q <= first_reload;
      frac_q <= 7'h00;
      sc_q <= 7'h00;
    end else if (pre_tick) begin
      cnt_q <= reload_d;
      frac_q <= frac_d;
      sc_q <= (sc_q == sc_last) ? 7'h00 : 7'(sc_q + 7'h01);
    end else if (cnt_q != 12'h000) begin
      cnt_q <= 12'(cnt_q - 12'h001);
    end
  end

  // Oversampling counter: a bit lasts 16 or 8 sample ticks in async modes.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      os_q <= 5'h0f;
    end else if (restart) begin
      os_q <= 5'(spb - 5'h01);
    end else if (itick && is_async) begin
      os_q <= (os_q == 5'h00) ? 5'(spb - 5'h01) : 5'(os_q - 5'h01);
    end
  end

  // Master transfer clock: one half period per expiry.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      xck_q <= baud_pkg::RST_XCK;
    end else if (restart || !is_master) begin
      xck_q <= baud_pkg::RST_XCK;
    end else if (itick) begin
      xck_q <= ~xck_q;
    end
  end

  // Registered ticks; data changes on the rising edge, sampling on the fall.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sample_tick <= 1'b0;
      bit_tick <= 1'b0;
      setup_tick <= 1'b0;
    end else if (mode == baud_pkg::MODE_SYNC_SLAVE) begin
      sample_tick <= 1'b0;
      bit_tick <= pin_fall && enable;
      setup_tick <= pin_rise && enable;
    end else if (is_master) begin
      sample_tick <= 1'b0;
      bit_tick <= itick && xck_q;
      setup_tick <= itick && !xck_q;
    end else begin
      sample_tick <= itick;
      bit_tick <= itick && (os_q == 5'h00);
      setup_tick <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      transfer_clock_pin_out <= baud_pkg::RST_XCK;
      transfer_clock_pin_oe <= 1'b0;
      samples_per_bit <= baud_pkg::OS_NORMAL;
    end else begin
      transfer_clock_pin_out <= xck_q;
      transfer_clock_pin_oe <= is_master && enable;
      samples_per_bit <= spb;
    end
  end

  // Helper: cycles between internal ticks under a stable setting.
  logic [19:0] gap_q;
  logic seen_q;
  logic [19:0] exp_pos;
  assign exp_pos = 20'({8'h00, rate_period_setting} + 20'h00001) << mag;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gap_q <= 20'h00000;
      seen_q <= 1'b0;
    end else if (restart) begin
      gap_q <= 20'h00000;
      seen_q <= 1'b0;
    end else if (itick) begin
      gap_q <= 20'h00000;
      seen_q <= 1'b1;
    end else begin
      gap_q <= 20'(gap_q + 20'h00001);
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  sequence s_slave_fall;
    mode == baud_pkg::MODE_SYNC_SLAVE && enable && pin_fall;
  endsequence

  a_slave_pin_clock: assert property (
    s_slave_fall |=> bit_tick && !sample_tick)
    else $error("Slave bit tick did not follow pin fall.");
  a_master_drives_pin: assert property (
    is_master && enable |=> transfer_clock_pin_oe)
    else $error("Master mode does not drive the transfer clock.");
  a_slave_no_drive: assert property (
    mode == baud_pkg::MODE_SYNC_SLAVE |=> !transfer_clock_pin_oe)
    else $error("Slave mode drives the transfer clock.");
  a_pos_scale_gap: assert property (
    itick && seen_q && is_async && !neg |-> gap_q + 20'h1 == exp_pos)
    else $error("Sample period wrong for non-negative scale.");
  a_neg_scale_gap: assert property (
    itick && seen_q && neg |-> gap_q >= {8'h00, shr} &&
      gap_q <= {8'h00, shr} + 20'h1)
    else $error("Fractional sample period out of range.");
  a_sync_half_period: assert property (
    itick && seen_q && is_master |->
      gap_q == {8'h00, rate_period_setting})
    else $error("Master half period is not period plus one.");
  a_sample_count: assert property (
    is_async && !restart && $stable(cfg) |-> samples_per_bit ==
      (double_speed_select ? baud_pkg::OS_DOUBLE : baud_pkg::OS_NORMAL))
    else $error("Samples per bit do not match speed select.");
  a_restart_reload: assert property (
    enable && cfg != cfg_q |=> cnt_q == $past(first_reload) &&
      sc_q == 7'h00 && frac_q == 7'h00 && !sample_tick)
    else $error("Divider not restarted after a setting change.");
  a_disabled_quiet: assert property (
    !enable ##1 !enable |=> !sample_tick && !bit_tick && !setup_tick)
    else $error("Ticks issued while disabled.");
endmodule

// file: verif/xck_source.sv
// Far-party model that drives the transfer clock pin in slave operation.
`timescale 1ns/1ps
module xck_source (
  // Clock
  input wire logic clk,
  // Control
  input wire logic run,
  input wire logic [3:0] half,
  // Pin
  output logic pin
);
  logic [3:0] cnt_q = 4'h0;
  initial pin = 1'b0;
  // Moves off the rising edge, as a real far clock would be unrelated.
  // Each level lasts half clk periods; it rests low between frames.
  always @(negedge clk) begin
    if (!run) begin
      pin <= 1'b0;
      cnt_q <= 4'h0;
    end else if (cnt_q == half - 4'h1) begin
      pin <= ~pin;
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule

// file: verif/tb_top.sv
// Self-checking bench for the bit-rate clock generator.
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic enable = 1'b0;
  logic [1:0] clock_mode = 2'h0;
  logic double_speed_select = 1'b0;
  logic [11:0] rate_period_setting = 12'h000;
  logic [3:0] rate_scale_exponent = 4'h0;
  logic xck_run = 1'b0;
  logic pin_in, pin_out, pin_oe, sample_tick, bit_tick, setup_tick;
  logic [4:0] samples_per_bit;
  int n_mismatch = 0;
  int checks_done = 0;
  int cycles = 0;
  int g, p, s, i, k;
  int s_tab[8] = '{0, 0, 1, 3, -1, -3, -2, 2};
  always #25 clk = ~clk;
  baud_clock_gen u_baud_clock_gen (.clk(clk), .resetn(resetn),
    .enable(enable), .clock_mode(clock_mode),
    .double_speed_select(double_speed_select),
    .rate_period_setting(rate_period_setting),
    .rate_scale_exponent(rate_scale_exponent),
    .transfer_clock_pin_in(pin_in), .transfer_clock_pin_out(pin_out),
    .transfer_clock_pin_oe(pin_oe), .sample_tick(sample_tick),
    .bit_tick(bit_tick), .setup_tick(setup_tick),
    .samples_per_bit(samples_per_bit));
  xck_source u_xck_source (.clk(clk), .run(xck_run), .half(4'h3),
    .pin(pin_in));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic results();
    if (n_mismatch == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Select 0 watches sample_tick, 1 bit_tick and 2 setup_tick.
  function automatic logic pick(input int sel);
    return sel == 0 ? sample_tick : (sel == 1 ? bit_tick : setup_tick);
  endfunction
  // Cycles between two consecutive ticks, seen at falling edges.
  task automatic gap(input int sel, output int n);
    int w;
    n = 0;
    w = 0;
    while (pick(sel) !== 1'b1 && w < 20000) begin
      @(negedge clk);
      w++;
    end
    do begin
      @(negedge clk);
      n++;
    end while (pick(sel) !== 1'b1 && n < 20000);
  endtask
  // Cycles for which the master transfer clock stays high.
  task automatic high_len(output int n);
    int w;
    n = 0;
    w = 0;
    while (pin_out !== 1'b0 && w < 20000) begin
      @(negedge clk);
      w++;
    end
    while (pin_out !== 1'b1 && w < 20000) begin
      @(negedge clk);
      w++;
    end
    do begin
      @(negedge clk);
      n++;
    end while (pin_out === 1'b1 && n < 20000);
  endtask
  task automatic count_ticks(output int n);
    n = 0;
    repeat (40) begin
      @(negedge clk);
      n += int'(bit_tick === 1'b1) + int'(sample_tick === 1'b1);
      n += int'(setup_tick === 1'b1);
    end
  endtask
  task automatic cfg(input int m, input int d, input int pp, input int ss);
    @(posedge clk);
    clock_mode <= 2'(m);
    double_speed_select <= 1'(d);
    rate_period_setting <= 12'(pp);
    rate_scale_exponent <= 4'(ss);
    repeat (3) @(negedge clk);
  endtask
  // Expected tick spacing from the rate formulas.
  function automatic int exp_gap(int m, int d, int pp, int ss, bit b);
    int os;
    os = d ? 8 : 16;
    if (m != 0)
      return 2 * (pp + 1);
    if (ss >= 0)
      return (pp + 1) * (1 << ss) * (b ? os : 1);
    return ((pp >> (-ss)) + 1) * (b ? os : 1);
  endfunction
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      n_mismatch++;
      results();
    end
  end
  initial begin
    void'($urandom(84090));
    @(posedge clk);
    @(negedge clk);
    check({pin_out, pin_oe, sample_tick, bit_tick, setup_tick}, 0);
    check(32'(samples_per_bit), 32'h10);
    @(posedge clk);
    resetn <= 1'b1;
    enable <= 1'b1;
    for (i = 0; i < 8; i++) begin
      s = s_tab[i];
      // Negative scales use a period that divides evenly, so sums are exact.
      p = s < 0 ? $urandom_range(1, 4) << (-s) : $urandom_range(1, 6);
      cfg(0, i % 2, p, s);
      gap(1'b0, g);
      check(g, exp_gap(0, i % 2, p, s, 1'b0));
      gap(1'b1, g);
      check(g, exp_gap(0, i % 2, p, s, 1'b1));
      check(32'(samples_per_bit), i % 2 ? 32'h08 : 32'h10);
    end
    cfg(0, 1, 0, 0);
    gap(1'b1, g);
    check(g, 8);
    // A zero period with scale s is replaced by period 2^s-1, scale zero.
    s = $urandom_range(1, 7);
    cfg(0, 0, (1 << s) - 1, 0);
    gap(1'b0, g);
    check(g, 1 << s);
    for (i = 0; i < 6; i++) begin
      p = i == 2 ? 4095 : (i % 3 == 0 ? 0 : $urandom_range(1, 30));
      cfg(i < 3 ? 1 : 3, 1, p, p == 0 ? 0 : $urandom_range(1, 7));
      gap(1'b1, g);
      check(g, exp_gap(1, 0, p, 0, 1'b1));
      check({pin_oe, sample_tick}, 32'h2);
      high_len(g);
      check(g, p + 1);
      gap(2, g);
      check(g, exp_gap(1, 0, p, 0, 1'b1));
    end
    cfg(0, 1, 9, 0);
    gap(1'b0, g);
    repeat (3) @(negedge clk);
    @(posedge clk);
    rate_period_setting <= 12'h002;
    g = 0;
    do begin
      @(negedge clk);
      g++;
    end while (sample_tick !== 1'b1 && g < 100);
    check(g, 5);
    cfg(2, 0, $urandom_range(1, 9), 0);
    xck_run <= 1'b1;
    gap(1'b1, g);
    check(g, 6);
    check(32'(pin_oe), 0);
    gap(2, g);
    check(g, 6);
    xck_run <= 1'b0;
    repeat (10) @(negedge clk);
    count_ticks(k);
    check(k, 0);
    cfg(1, 0, 2, 0);
    @(posedge clk);
    enable <= 1'b0;
    repeat (4) @(negedge clk);
    count_ticks(k);
    check(k, 0);
    check({pin_out, pin_oe}, 0);
    results();
  end
endmodule
